// file: design/epi_defs.svh
// Constants and register map for the external pin interrupt block
`ifndef EPI_DEFS_SVH
`define EPI_DEFS_SVH

`define EPI_NCH          4
`define EPI_OFS_SENSE    12'h000
`define EPI_OFS_ENABLE   12'h004
`define EPI_OFS_FLAGS    12'h008
`define EPI_OFS_CORE     12'h00c
`define EPI_OFS_STATUS   12'h010
`define EPI_SENSE_RST    8'h00
`define EPI_ENABLE_RST   4'h0
`define EPI_FLAGS_RST    4'h0
`define EPI_SENSE_LOW    2'h0
`define EPI_SENSE_CHANGE 2'h1
`define EPI_SENSE_FALL   2'h2
`define EPI_SENSE_RISE   2'h3
`define EPI_GIE_BIT      0
`define EPI_STARTUP_DEF  16'h0040

`endif

// file: design/epi_pkg.sv
// Types shared by the external pin interrupt block
package epi_pkg;
  typedef logic [1:0] epi_sense_t;
  typedef enum logic [1:0] {
    EPI_WAKE_IDLE,
    EPI_WAKE_SAMPLE,
    EPI_WAKE_STARTUP
  } epi_wake_state_t;
endpackage

// file: design/epi_sync.sv
// Two-stage synchroniser with edge memory for the interrupt pins
`timescale 1ns/1ps
`include "epi_defs.svh"
module epi_sync
  import epi_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ce_i,
  input  wire logic [`EPI_NCH-1:0]   pin_i,
  output logic      [`EPI_NCH-1:0]   cur_o,
  output logic      [`EPI_NCH-1:0]   prev_o
);

  logic [`EPI_NCH-1:0] meta_q;
  logic [`EPI_NCH-1:0] meta_d;
  logic [`EPI_NCH-1:0] cur_q;
  logic [`EPI_NCH-1:0] cur_d;
  logic [`EPI_NCH-1:0] prev_q;
  logic [`EPI_NCH-1:0] prev_d;

  // ------------------------------------------------------------
  // Sampling chain
  // ------------------------------------------------------------
  // Pins idle high after reset so no false fall is seen
  always_comb begin
    meta_d = ce_i ? pin_i  : meta_q;
    cur_d  = ce_i ? meta_q : cur_q;
    prev_d = ce_i ? cur_q  : prev_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      meta_q <= '1;
      cur_q  <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= meta_d;
      cur_q  <= cur_d;
      prev_q <= prev_d;
    end
  end

  assign cur_o  = cur_q;
  assign prev_o = prev_q;
endmodule

// file: design/epi_wake.sv
// Power-down level wake-up sampler on the watchdog tick
`timescale 1ns/1ps
module epi_wake
  import epi_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        power_down_i,
  input  wire logic        wdt_tick_i,
  input  wire logic        level_req_i,
  input  wire logic [15:0] startup_cycles_i,
  output logic             wake_o,
  output logic             level_irq_ok_o
);
`include "epi_defs.svh"

  epi_wake_state_t state_q;
  epi_wake_state_t state_d;
  logic [15:0]     cnt_q;
  logic [15:0]     cnt_d;
  logic            wake_q;
  logic            wake_d;
  logic            ok_q;
  logic            ok_d;

  // ------------------------------------------------------------
  // Wake sequence
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wake_d  = 1'b0;
    ok_d    = ok_q;
    case (state_q)
      EPI_WAKE_IDLE: begin
        ok_d = 1'b1;
        if (power_down_i && level_req_i && wdt_tick_i) begin
          state_d = EPI_WAKE_SAMPLE;
        end
      end
      EPI_WAKE_SAMPLE: begin
        if (!level_req_i) begin
          state_d = EPI_WAKE_IDLE;
        end else if (wdt_tick_i) begin
          // Second sample seen: wake is now committed
          state_d = EPI_WAKE_STARTUP;
          cnt_d   = startup_cycles_i;
          wake_d  = 1'b1;
        end
      end
      EPI_WAKE_STARTUP: begin
        if (!level_req_i) begin
          ok_d = 1'b0;
        end
        if (cnt_q == 16'h0000) begin
          state_d = EPI_WAKE_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: state_d = EPI_WAKE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= EPI_WAKE_IDLE;
      cnt_q   <= 16'h0000;
      wake_q  <= 1'b0;
      ok_q    <= 1'b1;
    end else if (ce_i) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wake_q  <= wake_d;
      ok_q    <= ok_d;
    end
  end

  assign wake_o         = wake_q;
  assign level_irq_ok_o = ok_q && (state_q != EPI_WAKE_STARTUP);
endmodule

// file: design/epi_top.sv
// External pin interrupt controller with AHB-Lite register slave
`timescale 1ns/1ps
`include "epi_defs.svh"
module epi_top
  import epi_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  input  wire logic                ce_i,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic      [31:0]         hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  input  wire logic [`EPI_NCH-1:0] ext_irq_pins_i,
  input  wire logic                io_clk_run_i,
  input  wire logic                power_down_i,
  input  wire logic                wdt_tick_i,
  input  wire logic [`EPI_NCH-1:0] irq_ack_i,
  output logic      [`EPI_NCH-1:0] irq_req_o,
  output logic                     wake_o
);

  logic [`EPI_NCH-1:0] pin_cur;
  logic [`EPI_NCH-1:0] pin_prev;
  logic [`EPI_NCH-1:0] trig;
  logic [`EPI_NCH-1:0] lvl;
  logic                lvl_any;
  logic                lvl_ok;
  logic                wake_lvl;

  logic [7:0]          sense_q;
  logic [7:0]          sense_d;
  logic [`EPI_NCH-1:0] enable_q;
  logic [`EPI_NCH-1:0] enable_d;
  logic [`EPI_NCH-1:0] flags_q;
  logic [`EPI_NCH-1:0] flags_d;
  logic                gie_q;
  logic                gie_d;
  logic [15:0]         startup_q;
  logic [15:0]         startup_d;

  logic                wr_pend_q;
  logic                wr_pend_d;
  logic [11:0]         wr_addr_q;
  logic [11:0]         wr_addr_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;

  logic                addr_phase;
  logic [31:0]         rd_word;

  // ------------------------------------------------------------
  // Pin sampling and wake-up
  // ------------------------------------------------------------
  // Pins are sampled whether the pad is an input or an output
  epi_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .pin_i     (ext_irq_pins_i),
    .cur_o     (pin_cur),
    .prev_o    (pin_prev)
  );

  epi_wake u_wake (
    .clk_sys_i        (clk_sys_i),
    .rstn_i           (rstn_i),
    .ce_i             (ce_i),
    .power_down_i     (power_down_i),
    .wdt_tick_i       (wdt_tick_i),
    .level_req_i      (lvl_any),
    .startup_cycles_i (startup_q),
    .wake_o           (wake_lvl),
    .level_irq_ok_o   (lvl_ok)
  );

  // ------------------------------------------------------------
  // Sense decode
  // ------------------------------------------------------------
  function automatic logic sense_hit(input epi_sense_t s, input logic cur,
                                     input logic prev);
    logic hit;
    hit = 1'b0;
    case (s)
      `EPI_SENSE_LOW:    hit = !cur;
      `EPI_SENSE_CHANGE: hit = cur ^ prev;
      `EPI_SENSE_FALL:   hit = prev && !cur;
      `EPI_SENSE_RISE:   hit = !prev && cur;
      default:           hit = 1'b0;
    endcase
    return hit;
  endfunction

  for (genvar n = 0; n < `EPI_NCH; n++) begin : g_ch
    logic is_lvl;
    logic hit;
    assign is_lvl = (sense_q[2*n +: 2] == `EPI_SENSE_LOW);
    assign hit    = sense_hit(sense_q[2*n +: 2], pin_cur[n], pin_prev[n]);
    // Edges only while the I/O clock runs
    assign trig[n] = !is_lvl && hit && io_clk_run_i;
    assign lvl[n]  = is_lvl && hit;
  end

  assign lvl_any = |(lvl & enable_q);

  // ------------------------------------------------------------
  // Register write and flag state
  // ------------------------------------------------------------
  always_comb begin
    sense_d   = sense_q;
    enable_d  = enable_q;
    gie_d     = gie_q;
    startup_d = startup_q;
    flags_d   = flags_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `EPI_OFS_SENSE:  sense_d = hwdata_i[7:0];
        `EPI_OFS_ENABLE: enable_d = hwdata_i[`EPI_NCH-1:0];
        `EPI_OFS_FLAGS:  flags_d = flags_q & ~hwdata_i[`EPI_NCH-1:0];
        `EPI_OFS_CORE: begin
          gie_d     = hwdata_i[`EPI_GIE_BIT];
          startup_d = hwdata_i[31:16];
        end
        default: ;
      endcase
    end
    // Acknowledge clears the serviced flag
    flags_d = flags_d & ~irq_ack_i;
    // Set wins over write and ack clears in the same cycle; a level sense setting still clears it
    flags_d = flags_d | trig;
    for (int n = 0; n < `EPI_NCH; n++) begin
      if (sense_d[2*n +: 2] == `EPI_SENSE_LOW) begin
        flags_d[n] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sense_q   <= `EPI_SENSE_RST;
      enable_q  <= `EPI_ENABLE_RST;
      flags_q   <= `EPI_FLAGS_RST;
      gie_q     <= 1'b0;
      startup_q <= `EPI_STARTUP_DEF;
    end else if (ce_i) begin
      sense_q   <= sense_d;
      enable_q  <= enable_d;
      flags_q   <= flags_d;
      gie_q     <= gie_d;
      startup_q <= startup_d;
    end
  end

  // ------------------------------------------------------------
  // Requests to the core
  // ------------------------------------------------------------
  // Level requests are suppressed during start-up, and for one cycle after it when the level vanished during start-up
  assign irq_req_o = gie_q ? (enable_q & (flags_q | (lvl & {`EPI_NCH{lvl_ok}})))
                           : '0;
  assign wake_o    = wake_lvl;

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  assign addr_phase = hsel_i && hready_i && htrans_i[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr_i[11:0])
      `EPI_OFS_SENSE:  rd_word[7:0] = sense_q;
      `EPI_OFS_ENABLE: rd_word[`EPI_NCH-1:0] = enable_q;
      `EPI_OFS_FLAGS:  rd_word[`EPI_NCH-1:0] = flags_q;
      `EPI_OFS_CORE: begin
        rd_word[`EPI_GIE_BIT] = gie_q;
        rd_word[31:16]        = startup_q;
      end
      `EPI_OFS_STATUS: begin
        rd_word[`EPI_NCH-1:0] = pin_cur;
        rd_word[8]            = lvl_ok;
      end
      default: rd_word = 32'h0000_0000;
    endcase
    wr_pend_d = addr_phase && hwrite_i;
    wr_addr_d = addr_phase ? haddr_i[11:0] : wr_addr_q;
    rdata_d   = (addr_phase && !hwrite_i) ? rd_word : rdata_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q   <= 32'h0000_0000;
    end else if (ce_i) begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  // Zero wait states; unmapped words read zero, writes dropped
  assign hrdata_o    = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
endmodule

// file: verif/epi_src.sv
// Behavioural model of the sources that drive the four interrupt pins
`timescale 1ns/1ps
module epi_src (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] lvl_i,
  output logic      [3:0] pins_o
);
  // Levels move only on clock edges, so no pulse is shorter than a cycle
  // A commanded low is held until the bench releases it
  always_ff @(posedge clk_sys_i) begin
    pins_o <= lvl_i;
  end
endmodule

// file: verif/epi_top_sva.sv
// Port-level assertions for the external pin interrupt block
`timescale 1ns/1ps
module epi_top_chk (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [3:0]  ext_irq_pins_i,
  input wire logic        power_down_i,
  input wire logic        wdt_tick_i,
  input wire logic [3:0]  irq_ack_i,
  input wire logic [3:0]  irq_req_o,
  input wire logic        wake_o
);
  logic rd_take;
  logic bus_idle;
  assign rd_take  = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign bus_idle = !(hsel_i && htrans_i[1]);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rstn_i |=> irq_req_o == 4'h0 && !wake_o) else $error("outputs active after reset");
  chk_resp_okay: assert property (hresp_o == 1'b0 && hreadyout_o)
    else $error("bus answer not ready and okay");
  chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o))
    else $error("read data moved without a read");
  chk_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  chk_wake_cause: assert property (wake_o |-> $past(power_down_i) &&
    ($past(wdt_tick_i) || $past(wdt_tick_i, 2))) else $error("wake without tick");
  chk_wake_level: assert property (wake_o |->
    ($past(ext_irq_pins_i, 3) != 4'hf) || ($past(ext_irq_pins_i, 4) != 4'hf))
    else $error("wake without a low pin");
  // Six high samples flush the synchroniser, so no set can race the ack
  chk_ack_clears: assert property (ext_irq_pins_i[0] [*6] ##0 irq_ack_i[0]
    |=> !irq_req_o[0]) else $error("ack did not drop request");
  chk_req_quiet: assert property ((ext_irq_pins_i[0] && bus_idle) [*6]
    ##0 !irq_req_o[0] |=> !irq_req_o[0]) else $error("request without cause");
  cover property (wake_o);
  cover property ($rose(irq_req_o[0]));
  cover property (rd_take);
endmodule

bind epi_top epi_top_chk u_epi_top_chk (
  .clk_sys_i, .rstn_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .ext_irq_pins_i, .power_down_i, .wdt_tick_i,
  .irq_ack_i, .irq_req_o, .wake_o
);

// file: verif/external_pin_interrupts_bench.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`include "epi_defs.svh"
module external_pin_interrupts_bench;
  localparam logic [11:0] a_se = `EPI_OFS_SENSE;
  localparam logic [11:0] a_en = `EPI_OFS_ENABLE;
  localparam logic [11:0] a_fl = `EPI_OFS_FLAGS;
  localparam logic [11:0] a_co = `EPI_OFS_CORE;
  localparam logic [4:0]  cases [7] = '{5'h05, 5'h0d, 5'h0b, 5'h15, 5'h12, 5'h1b, 5'h1c};
  logic        clk, rstn, hsel, hwrite, hrdy, hresp, io_run, pd, tick, wake, ef;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lvl, pins, ack, req;
  logic [4:0]  c;
  int          failures, compares, n;

  epi_top u_epi_top (.clk_sys_i(clk), .rstn_i(rstn), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .ext_irq_pins_i(pins), .io_clk_run_i(io_run),
    .power_down_i(pd), .wdt_tick_i(tick), .irq_ack_i(ack), .irq_req_o(req),
    .wake_o(wake));
  epi_src u_epi_src (.clk_sys_i(clk), .lvl_i(lvl), .pins_o(pins));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for the slave's ready; a hang ends the run
  task automatic wait_rdy;
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (hrdy === 1'b1) break;
    end
    if (k == 40) begin
      failures++;
      complete_run;
    end
  endtask

  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Read at the next edge before it lands; only channel 0 may ever request here
  task automatic chkreq(input logic exp);
    @(posedge clk);
    chk({28'h0, req}, {31'h0, exp});
  endtask

  task automatic arm(input logic [1:0] s, input logic st);
    ahb(1'b1, a_en, 32'h0);
    lvl <= {3'h7, st};
    repeat (6) @(posedge clk);
    ahb(1'b1, a_se, {30'h0, s});
    ahb(1'b1, a_fl, 32'hf);
    ahb(1'b1, a_en, 32'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata, pd, tick, ack} = '0;
    {hsize, lvl, io_run, failures, compares} = {3'h2, 4'hf, 1'b1, 64'h0};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(a_se, 32'h0);
    rdchk(a_en, 32'h0);
    rdchk(a_fl, 32'h0);
    ahb(1'b1, a_se, 32'hffffffff);
    rdchk(a_se, 32'hff);
    ahb(1'b1, a_en, 32'hffffffff);
    rdchk(a_en, 32'hf);
    ahb(1'b1, 12'h100, 32'hffffffff);
    rdchk(12'h100, 32'h0);
    ahb(1'b1, a_co, {`EPI_STARTUP_DEF, 16'h1});
    // Each case: sense, level before, level after, expected request
    for (int i = 0; i < 7; i++) begin
      c = cases[i];
      arm(c[4:3], c[2]);
      lvl <= {3'h7, c[1]};
      repeat (6) @(posedge clk);
      chkreq(c[0]);
      ef = (c[4:3] != 2'h0) && c[0];
      rdchk(a_fl, {31'h0, ef});
      ahb(1'b1, a_fl, 32'h0);
      rdchk(a_fl, {31'h0, ef});
      ahb(1'b1, a_co, {`EPI_STARTUP_DEF, 16'h0});
      chkreq(1'b0);
      ahb(1'b1, a_co, {`EPI_STARTUP_DEF, 16'h1});
      chkreq(c[0]);
      if (i[0]) begin
        ack <= 4'h1;
        @(posedge clk);
        ack <= 4'h0;
        @(posedge clk);
      end else begin
        ahb(1'b1, a_fl, 32'h1);
      end
      chkreq(c[0] && c[4:3] == 2'h0);
    end
    arm(2'h2, 1'b1);
    io_run <= 1'b0;
    lvl <= 4'he;
    repeat (6) @(posedge clk);
    chkreq(1'b0);
    io_run <= 1'b1;
    pd <= 1'b1;
    arm(2'h0, 1'b0);
    for (int t = 0; t < 2; t++) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      if (t == 0) repeat (4) @(posedge clk);
    end
    // Wake is a one-cycle pulse, so watch every edge from the second tick on
    for (n = 0; n < 20 && wake !== 1'b1; n++) begin
      @(posedge clk);
    end
    chk({31'h0, wake}, 32'h1);
    chkreq(1'b0);
    repeat (80) @(posedge clk);
    chkreq(1'b1);
    ahb(1'b1, a_en, 32'hf);
    lvl <= 4'h0;
    repeat (6) @(posedge clk);
    chk({28'h0, req}, 32'hf);
    complete_run;
  end
endmodule
